/* File: core/ueb_core.sv */
// ueb_core: packet-count bookkeeping for three tx and three rx endpoints
// plus the shared control endpoint 0, with an avalon-mm register slave.
// assumes a packet engine beside it that reports loads, sends and arrivals.
//
// Operation
// - controller is host or device, never both; role switchable at run time.
// - IN served by tx side, OUT by rx side of endpoint.
// - control IN/OUT endpoint plus three configurable IN and OUT endpoints.
// - endpoint 0 uses lowest 64 bytes as one shared buffer.
// - each configurable half has its own transfer type.
// - software programs buffer start and size per configurable endpoint.
// - two packets queued only if buffer holds twice max packet.
// - double buffering off means one packet only.
// - per-endpoint double-buffer disable bit resets set.
// - armed bit set by software, or auto on max-size load.
// - single buffer send clears armed and not-empty, raises event.
// - double buffer: first arm clears armed at once with event.
// - double buffer: each send clears armed with event.
// - not-empty after send tells whether one or two fit.
// - rx accepts no more than rx max size per packet.
// - single buffer arrival sets waiting and full, raises event.
// - software clears waiting after unload; that sends acknowledge.
// - auto-release clears waiting and full after max-size unload.
// - double buffer: first packet sets waiting only, second sets full.
// - double buffer: clearing waiting with full set clears full, then re-sets waiting.
// - not ready endpoint answers NAK, unless a release acknowledge goes out in the same cycle.
`timescale 1ns/1ps
module ueb_core
  import ueb_pkg::*;
#(
  parameter int NUM_EP = UEB_NUM_EP
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // avalon-mm slave
  input  wire logic [UEB_AW-1:0]      avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // packet engine: index 0 is endpoint 0, 1..3 configurable
  input  wire logic [NUM_EP:0]        tx_load_done,
  input  wire logic [NUM_EP:0]        tx_load_max,
  input  wire logic [NUM_EP:0]        tx_sent,
  input  wire logic [NUM_EP:0]        rx_arrive,
  input  wire logic [10:0]            rx_arrive_len,
  input  wire logic [NUM_EP:0]        rx_unload_max,
  input  wire logic [NUM_EP:0]        in_token,
  input  wire logic [NUM_EP:0]        out_token,
  // status toward the engine and software
  output logic [NUM_EP:0]             tx_event,
  output logic [NUM_EP:0]             rx_event,
  output logic [NUM_EP:0]             tx_send_ok,
  output logic [NUM_EP:0]             rx_accept_ok,
  output logic [1:0]                  handshake,
  output logic                        device_active,
  output logic                        host_active,
  output logic                        ctl_soft_reset
);
  // address decode and 2-bit endpoint selects serve exactly three configurable endpoints
  if (NUM_EP != UEB_NUM_EP) begin : g_bad_num_ep
    $error("ueb_core: NUM_EP must be 3");
  end

  localparam int N = NUM_EP + 1;  // ep0 plus the configurable ones

  logic [1:0] mode_q, mode_d;  // host bit, soft reset bit
  logic [NUM_EP:1] txdb_q, txdb_d, rxdb_q, rxdb_d;
  logic [N-1:0] txarm_q, txarm_d, txauto_q, txauto_d, rxwait_q, rxwait_d;
  logic [N-1:0] rxfull_q, rxfull_d, rxauto_q, rxauto_d, txev_d, rxev_d, ack_d;
  logic [1:0] txcnt_q [N], txcnt_d [N];
  logic [1:0] txty_q [N], txty_d [N], rxty_q [N], rxty_d [N];
  logic [10:0] txmax_q [N], txmax_d [N], rxmax_q [N], rxmax_d [N];
  logic [10:0] txadr_q [N], txadr_d [N], rxadr_q [N], rxadr_d [N];
  logic [10:0] txsz_q [N], txsz_d [N], rxsz_q [N], rxsz_d [N];
  logic [31:0] rdata_d;
  logic        wait_q, wait_d;
  logic [1:0]  hs_d;
  logic [N-1:0] txok_d, rxok_d;

  logic        acc;
  logic [1:0]  wsel;
  assign acc    = (avs_read || avs_write) && wait_q;
  assign wsel   = avs_address[3:2];
  logic in_tx_win, in_rx_win;
  assign in_tx_win = avs_address >= UEB_OFF_TX_BASE && avs_address < UEB_OFF_RX_BASE;
  assign in_rx_win = avs_address >= UEB_OFF_RX_BASE && avs_address < 8'hA0;
  logic [1:0] rx_sel;
  assign rx_sel = 2'(((avs_address - UEB_OFF_RX_BASE) >> 4));
  logic [1:0] tx_sel;
  assign tx_sel = 2'(((avs_address - UEB_OFF_TX_BASE) >> 4));

  // double mode allowed only when disable clear and buffer holds two packets
  function automatic logic dbl(input logic dis, input logic [10:0] sz, input logic [10:0] mx);
    dbl = !dis && ({1'b0, sz} >= {mx, 1'b0});
  endfunction

  always_comb begin
    mode_d   = mode_q;
    txdb_d   = txdb_q;
    rxdb_d   = rxdb_q;
    txarm_d  = txarm_q;
    txauto_d = txauto_q;
    rxwait_d = rxwait_q;
    rxfull_d = rxfull_q;
    rxauto_d = rxauto_q;
    txcnt_d  = txcnt_q;
    txty_d   = txty_q;
    rxty_d   = rxty_q;
    txmax_d  = txmax_q;
    rxmax_d  = rxmax_q;
    txadr_d  = txadr_q;
    rxadr_d  = rxadr_q;
    txsz_d   = txsz_q;
    rxsz_d   = rxsz_q;
    txev_d   = '0;
    rxev_d   = '0;
    ack_d    = '0;
    hs_d     = UEB_HS_NONE;
    rdata_d  = UEB_UNMAPPED;
    wait_d   = 1'b1;
    // software side: one-cycle waitrequest, then complete
    if (acc) begin
      wait_d = 1'b0;
      if (avs_address == UEB_OFF_MODE) begin
        rdata_d = {30'h0, mode_q[1], mode_q[0]};
        // role change accepted only while soft reset held
        if (avs_write && avs_byteenable[0]) begin
          mode_d[1] = avs_writedata[UEB_B_SRST];
          if (mode_q[1])
            mode_d[0] = avs_writedata[UEB_B_HOST];
        end
      end else if (avs_address == UEB_OFF_TXDBDIS) begin
        rdata_d = {28'h0, txdb_q, 1'b0};
        if (avs_write && avs_byteenable[0])
          txdb_d = avs_writedata[3:1];
      end else if (avs_address == UEB_OFF_RXDBDIS) begin
        rdata_d = {28'h0, rxdb_q, 1'b0};
        if (avs_write && avs_byteenable[0])
          rxdb_d = avs_writedata[3:1];
      end else if (in_tx_win) begin
        unique case (wsel)
          UEB_W_CSR: begin
            rdata_d = {18'h0, txty_q[tx_sel], 3'h0, txauto_q[tx_sel], 6'h0,
                       txcnt_q[tx_sel] != 2'h0, txarm_q[tx_sel]};
            if (avs_write) begin
              if (avs_writedata[UEB_B_RDY] && !txarm_q[tx_sel])
                txarm_d[tx_sel] = 1'b1;
              txauto_d[tx_sel] = avs_writedata[UEB_B_AUTO];
              if (tx_sel != 2'h0)
                txty_d[tx_sel] = avs_writedata[UEB_B_TYPE+:2];
            end
          end
          UEB_W_MAXP: begin
            rdata_d = {21'h0, txmax_q[tx_sel]};
            if (avs_write)
              txmax_d[tx_sel] = avs_writedata[10:0];
          end
          UEB_W_FIFO: begin
            rdata_d = {5'h0, txsz_q[tx_sel], 5'h0, txadr_q[tx_sel]};
            if (avs_write && tx_sel != 2'h0) begin
              txadr_d[tx_sel] = avs_writedata[10:0];
              txsz_d[tx_sel]  = avs_writedata[26:16];
            end
          end
          UEB_W_CNT: rdata_d = {30'h0, txcnt_q[tx_sel]};
        endcase
      end else if (in_rx_win) begin
        unique case (wsel)
          UEB_W_CSR: begin
            rdata_d = {18'h0, rxty_q[rx_sel], 3'h0, rxauto_q[rx_sel], 6'h0,
                       rxfull_q[rx_sel], rxwait_q[rx_sel]};
            if (avs_write) begin
              rxauto_d[rx_sel] = avs_writedata[UEB_B_AUTO];
              if (rx_sel != 2'h0)
                rxty_d[rx_sel] = avs_writedata[UEB_B_TYPE+:2];
            end
          end
          UEB_W_MAXP: begin
            rdata_d = {21'h0, rxmax_q[rx_sel]};
            if (avs_write)
              rxmax_d[rx_sel] = avs_writedata[10:0];
          end
          UEB_W_FIFO: begin
            rdata_d = {5'h0, rxsz_q[rx_sel], 5'h0, rxadr_q[rx_sel]};
            if (avs_write && rx_sel != 2'h0) begin
              rxadr_d[rx_sel] = avs_writedata[10:0];
              rxsz_d[rx_sel]  = avs_writedata[26:16];
            end
          end
          UEB_W_CNT: rdata_d = 32'h0000_0000;
        endcase
      end
    end
    // endpoint bookkeeping; counting, sends and arrivals only while the host bit is clear
    for (int e = 0; e < N; e++) begin
      logic txd, rxd, swclr;
      txd   = (e == 0) ? 1'b0 : dbl(txdb_q[e == 0 ? 1 : e], txsz_q[e], txmax_q[e]);
      rxd   = (e == 0) ? 1'b0 : dbl(rxdb_q[e == 0 ? 1 : e], rxsz_q[e], rxmax_q[e]);
      swclr = acc && avs_write && in_rx_win && wsel == UEB_W_CSR && rx_sel == 2'(e)
              && !avs_writedata[UEB_B_RDY] && rxwait_q[e];
      if (tx_load_done[e] && txauto_q[e] && tx_load_max[e])
        txarm_d[e] = 1'b1;
      if (txarm_d[e] && !txarm_q[e] && !mode_q[0]) begin
        txcnt_d[e] = txcnt_q[e] + 2'h1;
        if (txd && txcnt_q[e] == 2'h0) begin
          txarm_d[e] = 1'b0;
          txev_d[e]  = 1'b1;
        end
      end
      if (tx_sent[e] && txcnt_d[e] != 2'h0 && !mode_q[0]) begin
        txcnt_d[e] = txcnt_d[e] - 2'h1;
        txarm_d[e] = 1'b0;
        txev_d[e]  = 1'b1;
      end
      // auto-release or software clear; second packet re-arms waiting
      if ((rxwait_q[e] && rxauto_q[e] && rx_unload_max[e]) || swclr) begin
        ack_d[e] = 1'b1;
        if (rxfull_q[e] && rxd) begin
          rxfull_d[e] = 1'b0;
          rxwait_d[e] = 1'b1;
        end else begin
          rxwait_d[e] = 1'b0;
          rxfull_d[e] = 1'b0;
        end
      end
      if (rx_arrive[e] && !mode_q[0] && rx_arrive_len <= rxmax_q[e]) begin
        // post-release state, so an arrival in the release cycle is kept
        if (!rxwait_d[e]) begin
          rxwait_d[e] = 1'b1;
          rxfull_d[e] = !rxd;
          rxev_d[e]   = 1'b1;
        end else if (rxd && !rxfull_d[e]) begin
          rxfull_d[e] = 1'b1;
          rxev_d[e]   = 1'b1;
        end
      end
    end
    // handshake for the token being served
    for (int e = 0; e < N; e++) begin
      if (in_token[e])
        hs_d = (txcnt_q[e] != 2'h0) ? UEB_HS_NONE : UEB_HS_NAK;
      if (out_token[e])
        hs_d = (rxok_d[e]) ? UEB_HS_ACK : UEB_HS_NAK;
    end
    if (|ack_d)
      hs_d = UEB_HS_ACK;
    // soft reset flushes count, armed, waiting and full of every endpoint
    if (mode_q[1]) begin
      txcnt_d  = '{default: 2'h0};
      txarm_d  = '0;
      rxwait_d = '0;
      rxfull_d = '0;
    end
  end

  always_comb begin
    for (int e = 0; e < N; e++) begin
      txok_d[e] = !mode_q[0] && txcnt_q[e] != 2'h0;
      rxok_d[e] = !mode_q[0] && (!rxwait_q[e] || (e != 0 && !rxfull_q[e] &&
                  dbl(rxdb_q[e == 0 ? 1 : e], rxsz_q[e], rxmax_q[e])));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q   <= 2'h0;
      txdb_q   <= UEB_DBDIS_RST;
      rxdb_q   <= UEB_DBDIS_RST;
      txarm_q  <= '0;
      txauto_q <= '0;
      rxwait_q <= '0;
      rxfull_q <= '0;
      rxauto_q <= '0;
      txcnt_q  <= '{default: 2'h0};
      txty_q   <= '{default: 2'h0};
      rxty_q   <= '{default: 2'h0};
      txmax_q  <= '{default: UEB_MAXP_RST};
      rxmax_q  <= '{default: UEB_MAXP_RST};
      txadr_q  <= '{default: UEB_FIFO_AD_RST};
      rxadr_q  <= '{default: UEB_FIFO_AD_RST};
      txsz_q   <= '{default: UEB_FIFO_SZ_RST};
      rxsz_q   <= '{default: UEB_FIFO_SZ_RST};
      wait_q   <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      tx_event <= '0;
      rx_event <= '0;
      tx_send_ok <= '0;
      rx_accept_ok <= '0;
      handshake <= UEB_HS_NONE;
      device_active <= 1'b0;
      host_active <= 1'b0;
      ctl_soft_reset <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      txdb_q   <= txdb_d;
      rxdb_q   <= rxdb_d;
      txarm_q  <= txarm_d;
      txauto_q <= txauto_d;
      rxwait_q <= rxwait_d;
      rxfull_q <= rxfull_d;
      rxauto_q <= rxauto_d;
      txcnt_q  <= txcnt_d;
      txty_q   <= txty_d;
      rxty_q   <= rxty_d;
      txmax_q  <= txmax_d;
      rxmax_q  <= rxmax_d;
      txadr_q  <= txadr_d;
      rxadr_q  <= rxadr_d;
      txsz_q   <= txsz_d;
      rxsz_q   <= rxsz_d;
      wait_q   <= wait_d;
      avs_readdata <= rdata_d;
      tx_event <= txev_d;
      rx_event <= rxev_d;
      tx_send_ok <= txok_d;
      rx_accept_ok <= rxok_d;
      handshake <= hs_d;
      device_active <= !mode_d[0] && !mode_d[1];
      host_active <= mode_d[0] && !mode_d[1];
      ctl_soft_reset <= mode_d[1];
    end
  end
  assign avs_waitrequest = wait_q;

  // steps of a send and of a refused IN token on endpoint 1
  sequence s_ep1_send;
    tx_sent[1] && txcnt_q[1] != 2'h0 && !mode_q[0] && !mode_q[1];
  endsequence
  sequence s_ep1_in_idle;
    in_token == 4'h2 && out_token == 4'h0 && txcnt_q[1] == 2'h0 && ack_d == '0;
  endsequence

  AST_ROLE_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
    !(device_active && host_active)) else $error("both roles active");
  AST_DBDIS_RST: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> txdb_q == UEB_DBDIS_RST) else $error("disable bits not set");
  AST_TX_CNT: assert property (@(posedge clk) disable iff (!rst_b)
    txcnt_q[1] <= 2'h2) else $error("tx count overflow");
  AST_RX_FULL: assert property (@(posedge clk) disable iff (!rst_b)
    rxfull_q[1] |-> rxwait_q[1]) else $error("full without waiting");
  AST_TX_SEND_EVT: assert property (@(posedge clk) disable iff (!rst_b)
    s_ep1_send |=> tx_event[1] && !txarm_q[1]) else $error("send did not clear armed");
  AST_IN_NAK: assert property (@(posedge clk) disable iff (!rst_b)
    s_ep1_in_idle |=> handshake == UEB_HS_NAK) else $error("idle endpoint did not refuse");
endmodule

/* File: inc/ueb_pkg.sv */
// ueb_pkg: register map, field positions, reset values and types for the
// usb device endpoint buffering block. assumes a 32-bit avalon-mm slave.
package ueb_pkg;
  localparam int UEB_NUM_EP  = 3;
  localparam int UEB_AW      = 8;
  localparam int UEB_MEM_AW  = 11;
  localparam int UEB_EP0_SIZE = 64;
  // register byte addresses
  localparam logic [7:0] UEB_OFF_MODE    = 8'h00;
  localparam logic [7:0] UEB_OFF_TXDBDIS = 8'h04;
  localparam logic [7:0] UEB_OFF_RXDBDIS = 8'h08;
  localparam logic [7:0] UEB_OFF_TX_BASE = 8'h20;
  localparam logic [7:0] UEB_OFF_RX_BASE = 8'h60;
  localparam logic [7:0] UEB_EP_STRIDE   = 8'h10;
  // per-endpoint word index within the stride
  localparam logic [1:0] UEB_W_CSR  = 2'h0;
  localparam logic [1:0] UEB_W_MAXP = 2'h1;
  localparam logic [1:0] UEB_W_FIFO = 2'h2;
  localparam logic [1:0] UEB_W_CNT  = 2'h3;
  // csr fields
  localparam int UEB_B_RDY    = 0;
  localparam int UEB_B_NEFULL = 1;
  localparam int UEB_B_AUTO   = 8;
  localparam int UEB_B_TYPE   = 12;
  // mode register fields
  localparam int UEB_B_HOST   = 0;
  localparam int UEB_B_SRST   = 1;
  localparam logic [2:0]  UEB_DBDIS_RST = 3'h7;
  localparam logic [10:0] UEB_MAXP_RST    = 11'h040;
  localparam logic [10:0] UEB_FIFO_SZ_RST = 11'(UEB_EP0_SIZE);
  localparam logic [10:0] UEB_FIFO_AD_RST = 11'h000;
  localparam logic [31:0] UEB_UNMAPPED  = 32'h0000_0000;
  typedef enum logic [1:0] {
    UEB_TY_CTRL = 2'b00,
    UEB_TY_ISO  = 2'b01,
    UEB_TY_BULK = 2'b10,
    UEB_TY_INTR = 2'b11
  } ueb_type_t;
  typedef enum logic [1:0] {
    UEB_HS_NONE  = 2'b00,
    UEB_HS_ACK   = 2'b01,
    UEB_HS_NAK   = 2'b11
  } ueb_hs_t;
endpackage

/* File: tb/ueb_host_model.sv */
// ueb_host_model: usb host as the packet engine ports see it.
// assumes one xfer call at a time; every pulse lasts one clock.
`timescale 1ns/1ps
module ueb_host_model (
  // clock and device readiness
  input  wire logic        clk,
  input  wire logic [3:0]  tx_send_ok,
  // host traffic
  output logic [3:0]       in_token,
  output logic [3:0]       out_token,
  output logic [3:0]       tx_sent,
  output logic [3:0]       rx_arrive,
  output logic [10:0]      rx_arrive_len
);
  initial begin
    {in_token, out_token, tx_sent, rx_arrive} = 16'h0000;
    rx_arrive_len = 11'h555;
  end
  // lag delays the data phase to mimic a slow host
  task automatic xfer(input logic o, input int ep, input logic [10:0] len, input int lag);
    @(posedge clk);
    if (o) out_token <= 4'h1 << ep;
    else in_token <= 4'h1 << ep;
    @(posedge clk);
    {in_token, out_token} <= 8'h00;
    repeat (lag) @(posedge clk);
    rx_arrive_len <= len;
    if (o) rx_arrive <= 4'h1 << ep;
    else if (tx_send_ok[ep] === 1'b1) tx_sent <= 4'h1 << ep;
    @(posedge clk);
    {rx_arrive, tx_sent} <= 8'h00;
    // released length lines show garbage, not the old value
    rx_arrive_len <= ~len;
  endtask
endmodule

/* File: tb/usb_device_endpoint_buffering_tb.sv */
// usb_device_endpoint_buffering_tb: random and corner tests of ueb_core.
// assumes ueb_pkg and ueb_host_model are compiled before it.
`timescale 1ns/1ps
module usb_device_endpoint_buffering_tb;
  import ueb_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  tx_load_done = 4'h0;
  logic [3:0]  tx_load_max = 4'h0;
  logic [3:0]  rx_unload_max = 4'h0;
  logic [3:0]  in_token, out_token, tx_sent, rx_arrive, tx_event, rx_event, tx_send_ok, rx_accept_ok;
  logic [10:0] rx_arrive_len;
  logic [1:0]  handshake;
  logic [1:0]  hs_last = 2'h0;
  logic        device_active, host_active, ctl_soft_reset;
  logic [3:1]  dis [2] = '{3'h7, 3'h7};
  logic [31:0] cfg [2][4];
  logic [1:0]  modes [8] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2, 2'h0};
  int          ev_n [3][4] = '{default: 0};
  int          miscompares = 0;
  int          checks_done = 0;

  // cycle model only: the rate floor for real silicon is not modelled
  always #50 clk = ~clk;

  ueb_core i_dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .tx_load_done, .tx_load_max, .tx_sent, .rx_arrive, .rx_arrive_len,
    .rx_unload_max, .in_token, .out_token, .tx_event, .rx_event, .tx_send_ok, .rx_accept_ok, .handshake,
    .device_active, .host_active, .ctl_soft_reset);
  ueb_host_model i_host (.clk, .tx_send_ok, .in_token, .out_token, .tx_sent, .rx_arrive, .rx_arrive_len);

  // nonblocking counts so tasks read them without a race
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (tx_event[k] === 1'b1) ev_n[0][k] <= ev_n[0][k] + 1;
      if (rx_event[k] === 1'b1) ev_n[1][k] <= ev_n[1][k] + 1;
    end
    if (handshake !== UEB_HS_NONE) begin
      ev_n[2][0] <= ev_n[2][0] + 1;
      hs_last <= handshake;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int k, input int ep, input int old);
    for (int i = 0; i < 12 && ev_n[k][ep] == old; i++) @(posedge clk);
    if (ev_n[k][ep] == old) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 16) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q & m, exp & m);
  endtask

  function automatic logic [7:0] ea(input int rx, input int e, input int w);
    return (rx != 0 ? UEB_OFF_RX_BASE : UEB_OFF_TX_BASE) + UEB_EP_STRIDE * 8'(e) + 8'(4 * w);
  endfunction

  task automatic st(input int rx, input int e, input logic [1:0] m, input logic [1:0] exp);
    rd_chk(ea(rx, e, 0), {30'h0, m}, {30'h0, exp});
  endtask

  task automatic roles(input logic [2:0] exp);
    @(posedge clk);
    check({host_active, device_active, ctl_soft_reset}, exp);
  endtask

  // {host, device, soft reset} outputs expected for a mode word
  function automatic logic [2:0] role_exp(input logic [1:0] m);
    return {m[0] && !m[1], !m[0] && !m[1], m[1]};
  endfunction

  task automatic engine(input int ep, input logic ld, input logic mx);
    @(posedge clk);
    tx_load_done <= {3'h0, ld} << ep;
    tx_load_max <= {3'h0, ld & mx} << ep;
    rx_unload_max <= {3'h0, !ld & mx} << ep;
    @(posedge clk);
    {tx_load_done, tx_load_max, rx_unload_max} <= 12'h000;
  endtask

  task automatic setup(input int rx, input int e, input int mp, input int sz, input logic dbl, input logic au);
    // ep0 is control only, its type field stays zero
    cfg[rx][e] = {18'h0, ((e == 0) ? 2'h0 : 2'($urandom % 4)), 3'h0, au, 8'h00};
    wr(ea(rx, e, 1), 32'(mp));
    wr(ea(rx, e, 2), {5'h0, 11'(sz), 5'h0, 11'(128 * e + 512 * rx)});
    if (e > 0) dis[rx][e] = !dbl;
    wr(rx != 0 ? UEB_OFF_RXDBDIS : UEB_OFF_TXDBDIS, {28'h0, dis[rx], 1'b0});
    wr(ea(rx, e, 0), cfg[rx][e]);
    rd_chk(ea(rx, e, 0), 32'h0000_3100, cfg[rx][e]);
  endtask

  task automatic tok(input logic o, input int e, input logic [10:0] len, input logic [1:0] exp);
    int n;
    n = ev_n[2][0];
    i_host.xfer(o, e, len, 0);
    wait_n(2, 0, n);
    check(hs_last, exp);
  endtask

  task automatic rel(input int e);
    int n;
    n = ev_n[2][0];
    wr(ea(1, e, 0), cfg[1][e]);
    wait_n(2, 0, n);
    check(hs_last, UEB_HS_ACK);
  endtask

  initial begin
    int e, mp, n, k, len;
    logic [1:0] md;
    md = 2'h0;
    e = $urandom(32'h0fee);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(UEB_OFF_TXDBDIS, 32'hffff_ffff, 32'h0000_000e);
    rd_chk(UEB_OFF_RXDBDIS, 32'hffff_ffff, 32'h0000_000e);
    rd_chk(8'hfc, 32'hffff_ffff, UEB_UNMAPPED);
    for (k = 0; k < 8; k++) begin
      wr(UEB_OFF_MODE, {30'h0, modes[k]});
      // host bit follows only while the soft reset bit was already set
      md = {modes[k][1], md[1] ? modes[k][0] : md[0]};
      roles(role_exp(md));
    end
    // tx: ep0 by hand, ep1 auto-arm, ep2 too small to double, ep3 double
    for (e = 0; e < 4; e++) begin
      mp = (e == 0) ? 32 : 8 + $urandom % 57;
      setup(0, e, mp, (e == 2) ? mp : 2 * mp, e > 1, e == 1);
      tok(1'b0, e, 11'h000, UEB_HS_NAK);
      engine(e, 1'b1, 1'b0);
      n = ev_n[0][e];
      if (e == 1) begin
        st(0, e, 2'b01, 2'b00);
        engine(e, 1'b1, 1'b1);
      end else wr(ea(0, e, 0), cfg[0][e] | 32'h1);
      if (e == 3) begin
        wait_n(0, e, n);
        st(0, e, 2'b11, 2'b10);
        engine(e, 1'b1, 1'b0);
        wr(ea(0, e, 0), cfg[0][e] | 32'h1);
      end
      st(0, e, 2'b11, 2'b11);
      for (k = (e == 3) ? 0 : 1; k < 2; k++) begin
        n = ev_n[0][e];
        i_host.xfer(1'b0, e, 11'h000, $urandom % 4);
        wait_n(0, e, n);
        st(0, e, 2'b11, {k == 0, 1'b0});
        check({31'h0, tx_send_ok[e]}, {31'h0, k == 0});
      end
    end
    // rx: ep1 auto-release, ep2 single with oversize, ep3 double
    for (e = 1; e < 4; e++) begin
      mp = 8 + $urandom % 57;
      setup(1, e, mp, (e == 2) ? mp : 2 * mp, e > 1, e == 1);
      n = ev_n[1][e];
      if (e == 2) begin
        i_host.xfer(1'b1, e, 11'(mp + 1), 0);
        st(1, e, 2'b11, 2'b00);
        check(ev_n[1][e], n);
      end
      len = (e == 1) ? mp : 1 + $urandom % mp;
      for (k = (e == 3) ? 0 : 1; k < 2; k++) begin
        n = ev_n[1][e];
        i_host.xfer(1'b1, e, 11'(len), $urandom % 4);
        wait_n(1, e, n);
        st(1, e, 2'b11, {e != 3 || k == 1, 1'b1});
        check({31'h0, rx_accept_ok[e]}, {31'h0, e == 3 && k == 0});
      end
      if (e == 2) tok(1'b1, e, 11'(len), UEB_HS_NAK);
      if (e == 1) begin
        engine(e, 1'b0, 1'b1);
        st(1, e, 2'b11, 2'b00);
      end else begin
        if (e == 3) begin
          rel(e);
          st(1, e, 2'b11, 2'b01);
        end
        rel(e);
        st(1, e, 2'b11, 2'b00);
      end
    end
    wrap_up();
  end
endmodule
